/* lpcc_host.sv */
module lpcc_host (
  input  wire logic i_clk,
  input  wire logic i_sda,
  output logic      o_scl,
  output logic      o_sda
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----
  // bus master, open drain, 2.5 us per bit
  // ----
  localparam int T_LOW = 300;
  localparam int T_HI  = 325;
  initial begin
    o_scl = 1'b1;
    o_sda = 1'b1;
  end
  task automatic hw(input int n);
    repeat (n) @(negedge i_clk);
  endtask
  // start when a=1 b=0, stop when a=0 b=1
  task automatic edge2(input logic a, input logic b);
    hw(20);
    o_sda = a;
    hw(T_LOW - 20);
    o_scl = 1'b1;
    hw(T_HI / 2);
    o_sda = b;
    hw(T_HI / 2);
  endtask
  task automatic bit_x(input logic b, output logic r);
    hw(20);
    o_sda = b;
    hw(T_LOW - 20);
    o_scl = 1'b1;
    hw(T_HI);
    r = i_sda;
    o_scl = 1'b0;
  endtask
  task automatic tx(input logic [7:0] b, output logic nak);
    for (int i = 7; i >= 0; i--) begin
      bit_x(b[i], nak);
    end
    bit_x(1'b1, nak);
  endtask
  task automatic head(input logic [6:0] dev, input logic [7:0] ra, output logic [1:0] nak);
    edge2(1'b1, 1'b0);
    o_scl = 1'b0;
    tx({dev, 1'b0}, nak[1]);
    tx(ra, nak[0]);
  endtask
  task automatic wr(input logic [6:0] dev, input logic [7:0] ra, input logic [7:0] d, output logic [2:0] nak);
    head(dev, ra, nak[2:1]);
    tx(d, nak[0]);
    edge2(1'b0, 1'b1);
  endtask
  task automatic rd(input logic [7:0] ra, output logic [7:0] d, output logic [2:0] nak);
    logic n;
    head(7'h66, ra, nak[2:1]);
    edge2(1'b1, 1'b0);
    o_scl = 1'b0;
    tx({7'h66, 1'b1}, nak[0]);
    for (int i = 7; i >= 0; i--) begin
      bit_x(1'b1, d[i]);
    end
    bit_x(1'b1, n);
    edge2(1'b0, 1'b1);
  endtask
endmodule

/* lpcc_pkg.sv */
// Function
// - supply below lockout threshold forces every sink off regardless of on/off bits.
// - first enable rise makes device active with all sink currents at zero.
// - in shutdown all six sinks are high impedance drawing no current.
// - after power-up pump starts in 1x and stays while channels regulate.
// - enabled channel out of regulation in 1x moves pump to 1.5x after 400 us.
// - mode selection restarts from 1x on power-up, shutdown exit, on/off write.
// - four 8-bit registers at addresses 0, 1, 2 and 3.
// - current registers ignore bits 7 and 6, bits 5..0 hold the code.
// - on/off bits 0..5 switch channels A1..C2, 1 on, bits 7..6 ignored.
// - both channels of a pair share that pair's current code.
// - master can write and read back all four registers over the data line.
// - code N selects (N+1) half-milliampere steps, 0 minimum, 63 maximum.
// - device answers only to 7-bit bus address 1100110.
// - read is address write, repeated start with read bit, one unacknowledged byte.
// - serial interface works at bit rates up to 400 kbit/s.
package lpcc_pkg;

  localparam logic [6:0] DEV_ADDR       = 7'h66;
  localparam logic [7:0] REG_ADDR_MAX   = 8'h03;
  localparam logic [1:0] REG_PAIR_A     = 2'h0;
  localparam logic [1:0] REG_PAIR_B     = 2'h1;
  localparam logic [1:0] REG_PAIR_C     = 2'h2;
  localparam logic [1:0] REG_ON_OFF     = 2'h3;
  localparam int         NUM_REGS       = 4;
  localparam int         CODE_W         = 6;
  localparam int         CH_NUM         = 6;
  localparam logic [5:0] REG_RESET      = 6'h00;
  localparam logic [3:0] BITS_PER_BYTE  = 4'h8;

  // on/off bit positions
  localparam int ON_A1 = 0;
  localparam int ON_A2 = 1;
  localparam int ON_B1 = 2;
  localparam int ON_B2 = 3;
  localparam int ON_C1 = 4;
  localparam int ON_C2 = 5;

  localparam int BUS_RATE_KBPS   = 400;
  localparam int CLK_FREQ_MHZ    = 250;
  localparam int BOOST_DELAY_US  = 400;
  localparam int BOOST_DELAY_CYC = BOOST_DELAY_US * CLK_FREQ_MHZ;

  typedef enum logic [6:0] {
    BUS_IDLE = 7'b0000001,
    BUS_ADDR = 7'b0000010,
    BUS_REG  = 7'b0000100,
    BUS_WR   = 7'b0001000,
    BUS_ACK  = 7'b0010000,
    BUS_RD   = 7'b0100000,
    BUS_MACK = 7'b1000000
  } lpcc_bus_state_e;

  typedef enum logic [2:0] {
    PUMP_1X   = 3'b001,
    PUMP_WAIT = 3'b010,
    PUMP_1P5X = 3'b100
  } lpcc_pump_state_e;

endpackage

/* lpcc_props.sv */
module lpcc_props #(
  parameter int P_BOOST_DELAY_CYC = 20
) (
  input wire logic       i_sys_clk,
  input wire logic       i_rst_n,
  input wire logic [5:0] i_reg_fail,
  input wire logic       i_scl,
  input wire logic       o_sda_oe_n,
  input wire logic       o_sink_first_pair_ch1_on,
  input wire logic       o_sink_first_pair_ch2_on,
  input wire logic       o_sink_second_pair_ch1_on,
  input wire logic       o_sink_second_pair_ch2_on,
  input wire logic       o_sink_third_pair_ch1_on,
  input wire logic       o_sink_third_pair_ch2_on,
  input wire logic [6:0] o_pair_a_steps,
  input wire logic [6:0] o_pair_b_steps,
  input wire logic [6:0] o_pair_c_steps,
  input wire logic       o_sink_hiz,
  input wire logic       o_pump_1p5x,
  input wire logic       o_supply_low_lockout
);
  logic [5:0]  snk;
  logic        one_st;
  logic [31:0] run_q;
  logic [31:0] run_d;
  assign snk = {o_sink_third_pair_ch2_on, o_sink_third_pair_ch1_on, o_sink_second_pair_ch2_on,
                o_sink_second_pair_ch1_on, o_sink_first_pair_ch2_on, o_sink_first_pair_ch1_on};
  assign one_st = (o_pair_a_steps == 7'h01) && (o_pair_b_steps == 7'h01) && (o_pair_c_steps == 7'h01);
  // ----
  // cycles of any regulation failure in a row
  // ----
  always_comb begin
    run_d = (|i_reg_fail) ? run_q + 32'h1 : 32'h0;
  end
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      run_q <= 32'h0;
    end else begin
      run_q <= run_d;
    end
  end
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);
  a_lockout_sinks_off: assert property (o_supply_low_lockout && $past(o_supply_low_lockout) |-> snk == 6'h00)
    else $error("sink on in lockout");
  a_hiz_sinks_off: assert property (o_sink_hiz && $past(o_sink_hiz) |-> snk == 6'h00)
    else $error("sink on in shutdown");
  a_hiz_regs_clear: assert property (o_sink_hiz [*4] |-> one_st)
    else $error("current kept in shutdown");
  a_hiz_pump_1x: assert property (o_sink_hiz [*4] |-> !o_pump_1p5x)
    else $error("pump high in shutdown");
  a_enable_zero: assert property ($fell(o_sink_hiz) |-> one_st && snk == 6'h00)
    else $error("current at enable");
  a_boost_delay: assert property ($rose(o_pump_1p5x) |-> run_q >= 32'(P_BOOST_DELAY_CYC))
    else $error("pump raised early");
  a_answer_scl_low: assert property ($changed(o_sda_oe_n) |-> !i_scl && !$past(i_scl, 3))
    else $error("data moved near clock high");
  a_ack_held: assert property ($fell(o_sda_oe_n) |=> $stable(o_sda_oe_n) [*8])
    else $error("data low too short");
endmodule
bind lpcc_top lpcc_props #(.P_BOOST_DELAY_CYC(P_BOOST_DELAY_CYC)) i_props (
  .i_sys_clk, .i_rst_n, .i_reg_fail, .i_scl, .o_sda_oe_n,
  .o_sink_first_pair_ch1_on, .o_sink_first_pair_ch2_on, .o_sink_second_pair_ch1_on,
  .o_sink_second_pair_ch2_on, .o_sink_third_pair_ch1_on, .o_sink_third_pair_ch2_on,
  .o_pair_a_steps, .o_pair_b_steps, .o_pair_c_steps, .o_sink_hiz, .o_pump_1p5x, .o_supply_low_lockout
);

/* lpcc_sync.sv */
module lpcc_sync #(
  parameter int W = 1
) (
  input  wire logic         i_sys_clk,
  input  wire logic         i_rst_n,
  input  wire logic [W-1:0] i_d,
  output logic      [W-1:0] o_q
);

  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= i_d;
      sync_q <= meta_q;
    end
  end

  assign o_q = sync_q;

endmodule

/* lpcc_top.sv */
module lpcc_top #(
  parameter int P_BOOST_DELAY_CYC = lpcc_pkg::BOOST_DELAY_CYC
) (
  input  wire logic       i_sys_clk,
  input  wire logic       i_rst_n,
  input  wire logic       i_en,
  input  wire logic       i_supply_low,
  input  wire logic [5:0] i_reg_fail,
  input  wire logic       i_scl,
  input  wire logic       i_sda,
  output logic            o_sda_out,
  output logic            o_sda_oe_n,
  output logic            o_sink_first_pair_ch1_on,
  output logic            o_sink_first_pair_ch2_on,
  output logic            o_sink_second_pair_ch1_on,
  output logic            o_sink_second_pair_ch2_on,
  output logic            o_sink_third_pair_ch1_on,
  output logic            o_sink_third_pair_ch2_on,
  output logic [6:0]      o_pair_a_steps,
  output logic [6:0]      o_pair_b_steps,
  output logic [6:0]      o_pair_c_steps,
  output logic            o_sink_hiz,
  output logic            o_pump_1p5x,
  output logic            o_supply_low_lockout
);

  localparam int CNT_W = $clog2(P_BOOST_DELAY_CYC + 1);
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(P_BOOST_DELAY_CYC - 1);

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  logic [9:0] sync_out;
  logic       scl_n_s;
  logic       sda_n_s;
  logic       scl_s;
  logic       sda_s;
  logic       en_s;
  logic       low_s;
  logic [5:0] fail_s;

  // sampling at the system rate leaves wide margin at 400 kbit/s
  // bus pins pass inverted so reset leaves them at idle high, no false edge
  lpcc_sync #(.W(10)) u_sync (
    .i_sys_clk (i_sys_clk),
    .i_rst_n   (i_rst_n),
    .i_d       ({~i_scl, ~i_sda, i_en, i_supply_low, i_reg_fail}),
    .o_q       (sync_out)
  );

  assign {scl_n_s, sda_n_s, en_s, low_s, fail_s} = sync_out;
  assign scl_s = ~scl_n_s;
  assign sda_s = ~sda_n_s;

  // ----------------------------------------------------------------
  // edge detection
  // ----------------------------------------------------------------
  logic scl_prev_q;
  logic sda_prev_q;
  logic en_prev_q;
  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;
  logic en_rise;

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      scl_prev_q <= 1'b1;
      sda_prev_q <= 1'b1;
      en_prev_q  <= 1'b0;
    end else begin
      scl_prev_q <= scl_s;
      sda_prev_q <= sda_s;
      en_prev_q  <= en_s;
    end
  end

  assign scl_rise  = scl_s & ~scl_prev_q;
  assign scl_fall  = ~scl_s & scl_prev_q;
  assign bus_start = scl_s & scl_prev_q & ~sda_s & sda_prev_q;
  assign bus_stop  = scl_s & scl_prev_q & sda_s & ~sda_prev_q;
  assign en_rise   = en_s & ~en_prev_q;

  // ----------------------------------------------------------------
  // serial slave
  // ----------------------------------------------------------------
  lpcc_pkg::lpcc_bus_state_e bus_q, bus_d, nxt_q, nxt_d;
  logic [3:0] bcnt_q, bcnt_d;
  logic [7:0] shift_q, shift_d;
  logic [1:0] ptr_q, ptr_d;
  logic       oe_n_q, oe_n_d;
  logic       wr_strobe;
  logic [7:0] rd_byte;
  logic [5:0] regs_q [lpcc_pkg::NUM_REGS];
  logic [5:0] regs_d [lpcc_pkg::NUM_REGS];

  assign rd_byte = {2'b00, regs_q[ptr_q]};

  always_comb begin
    bus_d     = bus_q;
    nxt_d     = nxt_q;
    bcnt_d    = bcnt_q;
    shift_d   = shift_q;
    ptr_d     = ptr_q;
    oe_n_d    = oe_n_q;
    wr_strobe = 1'b0;
    if (!en_s) begin
      bus_d  = lpcc_pkg::BUS_IDLE;
      oe_n_d = 1'b1;
    end else if (bus_start) begin
      bus_d  = lpcc_pkg::BUS_ADDR;
      bcnt_d = 4'h0;
      oe_n_d = 1'b1;
    end else if (bus_stop) begin
      bus_d  = lpcc_pkg::BUS_IDLE;
      oe_n_d = 1'b1;
    end else begin
      case (bus_q)
        lpcc_pkg::BUS_IDLE: begin
          oe_n_d = 1'b1;
        end
        lpcc_pkg::BUS_ADDR, lpcc_pkg::BUS_REG, lpcc_pkg::BUS_WR: begin
          if (scl_rise && bcnt_q != lpcc_pkg::BITS_PER_BYTE) begin
            shift_d = {shift_q[6:0], sda_s};
            bcnt_d  = bcnt_q + 4'h1;
          end else if (scl_fall && bcnt_q == lpcc_pkg::BITS_PER_BYTE) begin
            bcnt_d = 4'h0;
            bus_d  = lpcc_pkg::BUS_ACK;
            oe_n_d = 1'b0;
            nxt_d  = lpcc_pkg::BUS_WR;
            if (bus_q == lpcc_pkg::BUS_ADDR) begin
              if (shift_q[7:1] == lpcc_pkg::DEV_ADDR) begin
                nxt_d = shift_q[0] ? lpcc_pkg::BUS_RD : lpcc_pkg::BUS_REG;
              end else begin
                bus_d  = lpcc_pkg::BUS_IDLE;
                oe_n_d = 1'b1;
              end
            end else if (bus_q == lpcc_pkg::BUS_REG) begin
              if (shift_q <= lpcc_pkg::REG_ADDR_MAX) begin
                ptr_d = shift_q[1:0];
              end else begin
                bus_d  = lpcc_pkg::BUS_IDLE;
                oe_n_d = 1'b1;
              end
            end else begin
              wr_strobe = 1'b1;
            end
          end
        end
        lpcc_pkg::BUS_ACK: begin
          if (scl_fall) begin
            bus_d  = nxt_q;
            oe_n_d = 1'b1;
            if (nxt_q == lpcc_pkg::BUS_RD) begin
              shift_d = rd_byte;
              oe_n_d  = rd_byte[7];
              bcnt_d  = 4'h1;
            end
          end
        end
        lpcc_pkg::BUS_RD: begin
          if (scl_fall) begin
            if (bcnt_q == lpcc_pkg::BITS_PER_BYTE) begin
              bus_d  = lpcc_pkg::BUS_MACK;
              oe_n_d = 1'b1;
              bcnt_d = 4'h0;
            end else begin
              oe_n_d  = shift_q[6];
              shift_d = {shift_q[6:0], 1'b0};
              bcnt_d  = bcnt_q + 4'h1;
            end
          end
        end
        lpcc_pkg::BUS_MACK: begin
          // missing acknowledge ends the read
          if (scl_rise) begin
            bus_d = sda_s ? lpcc_pkg::BUS_IDLE : lpcc_pkg::BUS_ACK;
            nxt_d = lpcc_pkg::BUS_RD;
          end
        end
        default: begin
          bus_d  = lpcc_pkg::BUS_IDLE;
          oe_n_d = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      bus_q   <= lpcc_pkg::BUS_IDLE;
      nxt_q   <= lpcc_pkg::BUS_IDLE;
      bcnt_q  <= 4'h0;
      shift_q <= 8'h00;
      ptr_q   <= 2'h0;
      oe_n_q  <= 1'b1;
    end else begin
      bus_q   <= bus_d;
      nxt_q   <= nxt_d;
      bcnt_q  <= bcnt_d;
      shift_q <= shift_d;
      ptr_q   <= ptr_d;
      oe_n_q  <= oe_n_d;
    end
  end

  // ----------------------------------------------------------------
  // register file
  // ----------------------------------------------------------------
  always_comb begin
    regs_d = regs_q;
    if (!en_s) begin
      for (int i = 0; i < lpcc_pkg::NUM_REGS; i++) begin
        regs_d[i] = lpcc_pkg::REG_RESET;
      end
    end else if (wr_strobe) begin
      regs_d[ptr_q] = shift_q[lpcc_pkg::CODE_W-1:0];
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      for (int i = 0; i < lpcc_pkg::NUM_REGS; i++) begin
        regs_q[i] <= lpcc_pkg::REG_RESET;
      end
    end else begin
      regs_q <= regs_d;
    end
  end

  // ----------------------------------------------------------------
  // pump mode selection
  // ----------------------------------------------------------------
  lpcc_pkg::lpcc_pump_state_e pump_q, pump_d;
  logic [CNT_W-1:0] dly_q, dly_d;
  logic             fail_any;
  logic             restart;

  assign fail_any = |(regs_q[lpcc_pkg::REG_ON_OFF] & fail_s);
  assign restart  = en_rise | (wr_strobe && ptr_q == lpcc_pkg::REG_ON_OFF);

  always_comb begin
    pump_d = pump_q;
    dly_d  = dly_q;
    if (!en_s || restart) begin
      pump_d = lpcc_pkg::PUMP_1X;
      dly_d  = '0;
    end else begin
      case (pump_q)
        lpcc_pkg::PUMP_1X: begin
          if (fail_any) begin
            pump_d = lpcc_pkg::PUMP_WAIT;
            dly_d  = '0;
          end
        end
        lpcc_pkg::PUMP_WAIT: begin
          if (!fail_any) begin
            pump_d = lpcc_pkg::PUMP_1X;
          end else if (dly_q == CNT_LAST) begin
            pump_d = lpcc_pkg::PUMP_1P5X;
          end else begin
            dly_d = dly_q + 1'b1;
          end
        end
        lpcc_pkg::PUMP_1P5X: begin
          pump_d = lpcc_pkg::PUMP_1P5X;
        end
        default: begin
          pump_d = lpcc_pkg::PUMP_1X;
        end
      endcase
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pump_q <= lpcc_pkg::PUMP_1X;
      dly_q  <= '0;
    end else begin
      pump_q <= pump_d;
      dly_q  <= dly_d;
    end
  end

  // ----------------------------------------------------------------
  // output stage
  // ----------------------------------------------------------------
  logic [5:0] on_q, on_d;
  logic [6:0] steps_q [3];
  logic [6:0] steps_d [3];
  logic       hiz_q, hiz_d;
  logic       p15_q, p15_d;
  logic       low_q, low_d;

  always_comb begin
    // zero current until on bits are programmed
    on_d  = (en_s && !low_s) ? regs_q[lpcc_pkg::REG_ON_OFF] : 6'h00;
    hiz_d = ~en_s;
    p15_d = (pump_q == lpcc_pkg::PUMP_1P5X);
    low_d = low_s;
    for (int i = 0; i < 3; i++) begin
      steps_d[i] = {1'b0, regs_q[i]} + 7'h01;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      on_q  <= 6'h00;
      hiz_q <= 1'b1;
      p15_q <= 1'b0;
      low_q <= 1'b0;
      for (int i = 0; i < 3; i++) begin
        steps_q[i] <= 7'h01;
      end
    end else begin
      on_q    <= on_d;
      hiz_q   <= hiz_d;
      p15_q   <= p15_d;
      low_q   <= low_d;
      steps_q <= steps_d;
    end
  end

  // open-drain data line only ever pulls low
  logic sda_out_q;

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sda_out_q <= 1'b0;
    end else begin
      sda_out_q <= 1'b0;
    end
  end

  assign o_sda_out                 = sda_out_q;
  assign o_sda_oe_n                = oe_n_q;
  assign o_sink_first_pair_ch1_on  = on_q[lpcc_pkg::ON_A1];
  assign o_sink_first_pair_ch2_on  = on_q[lpcc_pkg::ON_A2];
  assign o_sink_second_pair_ch1_on = on_q[lpcc_pkg::ON_B1];
  assign o_sink_second_pair_ch2_on = on_q[lpcc_pkg::ON_B2];
  assign o_sink_third_pair_ch1_on  = on_q[lpcc_pkg::ON_C1];
  assign o_sink_third_pair_ch2_on  = on_q[lpcc_pkg::ON_C2];
  assign o_pair_a_steps            = steps_q[lpcc_pkg::REG_PAIR_A];
  assign o_pair_b_steps            = steps_q[lpcc_pkg::REG_PAIR_B];
  assign o_pair_c_steps            = steps_q[lpcc_pkg::REG_PAIR_C];
  assign o_sink_hiz                = hiz_q;
  assign o_pump_1p5x               = p15_q;
  assign o_supply_low_lockout      = low_q;

endmodule

/* lpcc_top_tb.sv */
module lpcc_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic       i_sys_clk;
  logic       i_rst_n;
  logic       i_en;
  logic       i_supply_low;
  logic [5:0] i_reg_fail;
  logic       scl;
  logic       sda_h;
  logic       sda;
  logic       sda_out;
  logic       sda_oe_n;
  logic [5:0] sinks;
  logic [6:0] st_a;
  logic [6:0] st_b;
  logic [6:0] st_c;
  logic       hiz;
  logic       pump;
  logic       lock;
  logic [7:0] rdat;
  logic [2:0] nak;
  int         fails = 0;
  int         checks_done = 0;
  assign sda = sda_h & (sda_oe_n | sda_out);
  lpcc_top #(.P_BOOST_DELAY_CYC(20)) i_dut (
    .i_sys_clk, .i_rst_n, .i_en, .i_supply_low, .i_reg_fail, .i_scl(scl), .i_sda(sda),
    .o_sda_out(sda_out), .o_sda_oe_n(sda_oe_n),
    .o_sink_first_pair_ch1_on(sinks[0]), .o_sink_first_pair_ch2_on(sinks[1]),
    .o_sink_second_pair_ch1_on(sinks[2]), .o_sink_second_pair_ch2_on(sinks[3]),
    .o_sink_third_pair_ch1_on(sinks[4]), .o_sink_third_pair_ch2_on(sinks[5]),
    .o_pair_a_steps(st_a), .o_pair_b_steps(st_b), .o_pair_c_steps(st_c),
    .o_sink_hiz(hiz), .o_pump_1p5x(pump), .o_supply_low_lockout(lock)
  );
  lpcc_host i_host (.i_clk(i_sys_clk), .i_sda(sda), .o_scl(scl), .o_sda(sda_h));
  initial begin
    i_sys_clk = 1'b0;
    forever #2 i_sys_clk = ~i_sys_clk;
  end
  task automatic wt(input int n);
    repeat (n) @(negedge i_sys_clk);
  endtask
  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // ----
  // watchdog
  // ----
  initial begin
    // tests need about 97000 cycles
    repeat (100000) @(posedge i_sys_clk);
    fails++;
    test_done();
  end
  // ----
  // tests
  // ----
  initial begin
    i_rst_n = 1'b0;
    i_en = 1'b0;
    i_supply_low = 1'b0;
    i_reg_fail = 6'h00;
    wt(12);
    i_rst_n = 1'b1;
    i_en = 1'b1;
    wt(8);
    chk("steps_a", 8'h01, {1'b0, st_a});
    chk("sinks", 8'h00, {2'b00, sinks});
    chk("hiz", 8'h00, {7'h00, hiz});
    $display("reset test done");
    i_host.wr(7'h66, 8'h00, 8'hFF, nak);
    chk("wr_nak", 8'h00, {5'h00, nak});
    chk("steps_a", 8'h40, {1'b0, st_a});
    chk("steps_b", 8'h01, {1'b0, st_b});
    chk("steps_c", 8'h01, {1'b0, st_c});
    i_host.rd(8'h00, rdat, nak);
    chk("rd_a", 8'h3F, rdat);
    chk("rd_nak", 8'h00, {5'h00, nak});
    $display("register test done");
    i_reg_fail = 6'h04;
    wt(40);
    chk("pump", 8'h00, {7'h00, pump});
    i_host.wr(7'h66, 8'h03, 8'hC5, nak);
    chk("sinks", 8'h05, {2'b00, sinks});
    chk("pump", 8'h01, {7'h00, pump});
    i_supply_low = 1'b1;
    wt(8);
    chk("sinks", 8'h00, {2'b00, sinks});
    chk("lockout", 8'h01, {7'h00, lock});
    i_supply_low = 1'b0;
    wt(8);
    chk("sinks", 8'h05, {2'b00, sinks});
    i_host.wr(7'h66, 8'h03, 8'h00, nak);
    chk("pump", 8'h00, {7'h00, pump});
    $display("pump test done");
    i_host.wr(7'h67, 8'h00, 8'h05, nak);
    chk("bad_nak", 8'h07, {5'h00, nak});
    chk("steps_a", 8'h40, {1'b0, st_a});
    i_en = 1'b0;
    wt(8);
    chk("hiz", 8'h01, {7'h00, hiz});
    i_en = 1'b1;
    wt(8);
    chk("steps_a", 8'h01, {1'b0, st_a});
    $display("shutdown test done");
    test_done();
  end
endmodule
